// File: rtl/dcef_pkg.sv
// Package with register map, field positions and reset values for the block.
package dcef_pkg;

	// Byte addresses of the registers.
	localparam logic [7:0] DCEF_EVT_CTL_OFS = 8'h00;
	localparam logic [7:0] DCEF_RD_PTR_OFS = 8'h04;
	localparam logic [7:0] DCEF_IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] DCEF_IRQ_EN_OFS = 8'h0c;
	localparam logic [7:0] DCEF_IRQ_CLR_OFS = 8'h10;

	// Field positions in the channel event control register.
	localparam int DCEF_WR_SYNC_CLR_BIT = 15;
	localparam int DCEF_WR_SYNC_SEEN_BIT = 14;
	localparam int DCEF_RD_SYNC_CLR_BIT = 13;
	localparam int DCEF_RD_SYNC_SEEN_BIT = 12;
	localparam int DCEF_WR_DROP_EN_BIT = 11;
	localparam int DCEF_WR_DROP_FLAG_BIT = 10;
	localparam int DCEF_RD_DROP_EN_BIT = 9;
	localparam int DCEF_RD_DROP_FLAG_BIT = 8;
	localparam int DCEF_BLOCK_EN_BIT = 7;
	localparam int DCEF_BLOCK_FLAG_BIT = 6;
	localparam int DCEF_FINAL_EN_BIT = 5;
	localparam int DCEF_FINAL_FLAG_BIT = 4;
	localparam int DCEF_FRAME_EN_BIT = 3;
	localparam int DCEF_FRAME_FLAG_BIT = 2;
	localparam int DCEF_SPLIT_EN_BIT = 1;
	localparam int DCEF_SPLIT_FLAG_BIT = 0;

	// Event order in the interrupt status, enable and clear registers.
	localparam int DCEF_NUM_EVT = 8;
	localparam int DCEF_EV_SPLIT = 0;
	localparam int DCEF_EV_FRAME = 1;
	localparam int DCEF_EV_FINAL = 2;
	localparam int DCEF_EV_BLOCK = 3;
	localparam int DCEF_EV_RD_DROP = 4;
	localparam int DCEF_EV_WR_DROP = 5;
	localparam int DCEF_EV_RD_SYNC = 6;
	localparam int DCEF_EV_WR_SYNC = 7;

	// Values after reset.
	localparam logic [4:0] DCEF_CTL_EN_RST = 5'h10;
	localparam logic [31:0] DCEF_RD_PTR_RST = 32'h0000_0000;
	localparam logic [7:0] DCEF_EVT_RST = 8'h00;

	// Bus encodings.
	localparam logic [1:0] DCEF_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] DCEF_HTRANS_SEQ = 2'h3;

endpackage

// File: rtl/dcef_channel_events.sv
// Channel event flags, interrupt enables and read pointer behind AHB-Lite.
// Function
// - Write-sync seen flag at bit 14, set by write sync event, resets 0.
// - Writing 1 to bit 13 clears read-sync seen; writing 0 does nothing.
// - Read-sync seen flag at bit 12, set by read sync event, resets 0.
// - Bit 11 enables write-drop flag onto channel interrupt; resets 0.
// - Write-drop flag at bit 10 sets on dropped write sync; resets 0.
// - Bit 9 enables read-drop flag onto channel interrupt; resets 0.
// - Read-drop flag at bit 8 sets on dropped read sync; resets 0.
// - Bit 7 enables block-done flag onto interrupt; resets to 1.
// - Block-done flag at bit 6 sets when a block finishes; resets 0.
// - Bit 5 enables final-frame flag onto channel interrupt; resets 0.
// - Final-frame flag at bit 4 sets when last frame finishes; resets 0.
// - Bit 3 enables frame-done flag onto channel interrupt; resets 0.
// - Frame-done flag at bit 2 sets when a frame completes; resets 0.
// - Bit 1 enables split-overrun flag onto channel interrupt; resets 0.
// - Split-overrun flag at bit 0 sets on split overrun; resets 0.
// - Read pointer is a 32-bit read/write register reset to 0.
// - Writing 1 to bit 15 clears write-sync seen; writing 0 does nothing.
`timescale 1ns/1ps
`default_nettype none

module dcef_channel_events
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Event pulses from the transfer engine.
	input wire logic wrSyncEvt,
	input wire logic rdSyncEvt,
	input wire logic wrSyncLost,
	input wire logic rdSyncLost,
	input wire logic blockDone,
	input wire logic finalFrameDone,
	input wire logic frameDone,
	input wire logic splitOverrun,
	// Channel state.
	output logic [31:0] readPointer,
	output logic chanIrq,
	output logic evtIrq
);
	import dcef_pkg::*;

	// Flag and enable pairs in the control word, counted from bit 0.
	localparam int NumPair = 6;

	////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic wrSeen;
		logic rdSeen;
		logic wrDropEn;
		logic wrDropFlag;
		logic rdDropEn;
		logic rdDropFlag;
		logic blockEn;
		logic blockFlag;
		logic finalEn;
		logic finalFlag;
		logic frameEn;
		logic frameFlag;
		logic splitEn;
		logic splitFlag;
		logic [31:0] rdPtr;
		logic [7:0] evtStat;
		logic [7:0] evtEn;
		logic dataPh;
		logic dataWr;
		logic [7:0] dataAddr;
		logic [31:0] rdata;
	} dcef_state_t;

	dcef_state_t st_r;
	dcef_state_t st_nxt;
	logic [31:0] ctlWord;
	logic [7:0] evtIn;
	logic [7:0] evtClr;
	logic [7:0] evtStatNxt;
	logic [7:0] evtHit;
	logic [NumPair-1:0] pairFlag;
	logic [NumPair-1:0] pairEn;
	logic [NumPair-1:0] pairIrq;
	logic selCtl;
	logic selPtr;
	logic selEn;
	logic selClr;
	logic [31:0] rdWord;

	////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		ctlWord = 32'h0000_0000;
		ctlWord[DCEF_WR_SYNC_SEEN_BIT] = st_r.wrSeen;
		ctlWord[DCEF_RD_SYNC_SEEN_BIT] = st_r.rdSeen;
		ctlWord[DCEF_WR_DROP_EN_BIT] = st_r.wrDropEn;
		ctlWord[DCEF_WR_DROP_FLAG_BIT] = st_r.wrDropFlag;
		ctlWord[DCEF_RD_DROP_EN_BIT] = st_r.rdDropEn;
		ctlWord[DCEF_RD_DROP_FLAG_BIT] = st_r.rdDropFlag;
		ctlWord[DCEF_BLOCK_EN_BIT] = st_r.blockEn;
		ctlWord[DCEF_BLOCK_FLAG_BIT] = st_r.blockFlag;
		ctlWord[DCEF_FINAL_EN_BIT] = st_r.finalEn;
		ctlWord[DCEF_FINAL_FLAG_BIT] = st_r.finalFlag;
		ctlWord[DCEF_FRAME_EN_BIT] = st_r.frameEn;
		ctlWord[DCEF_FRAME_FLAG_BIT] = st_r.frameFlag;
		ctlWord[DCEF_SPLIT_EN_BIT] = st_r.splitEn;
		ctlWord[DCEF_SPLIT_FLAG_BIT] = st_r.splitFlag;
	end

	always_comb
	begin
		evtIn = 8'h00;
		evtIn[DCEF_EV_SPLIT] = splitOverrun;
		evtIn[DCEF_EV_FRAME] = frameDone;
		evtIn[DCEF_EV_FINAL] = finalFrameDone;
		evtIn[DCEF_EV_BLOCK] = blockDone;
		evtIn[DCEF_EV_RD_DROP] = rdSyncLost;
		evtIn[DCEF_EV_WR_DROP] = wrSyncLost;
		evtIn[DCEF_EV_RD_SYNC] = rdSyncEvt;
		evtIn[DCEF_EV_WR_SYNC] = wrSyncEvt;
	end

	////////////////////////////////////////////////////////////////////////

	// Each condition flag sits just below its enable in the control word,
	// so one loop forms every pair's share of the channel interrupt.
	for (genvar gi = 0; gi < NumPair; gi++)
	begin : g_pair
		assign pairFlag[gi] = ctlWord[2 * gi];
		assign pairEn[gi] = ctlWord[2 * gi + 1];
		assign pairIrq[gi] = pairFlag[gi] & pairEn[gi];
	end

	// Status bits are sticky: an event in the cycle of a clear still sets
	// its bit, so no event is lost to a late clear.
	for (genvar gi = 0; gi < DCEF_NUM_EVT; gi++)
	begin : g_evt
		assign evtClr[gi] = selClr & hwdata[gi];
		assign evtStatNxt[gi] = evtIn[gi] |
			(st_r.evtStat[gi] & ~evtClr[gi]);
		assign evtHit[gi] = st_r.evtStat[gi] & st_r.evtEn[gi];
	end

	////////////////////////////////////////////////////////////////////////

	// Write data only stands in the data phase, so writes decode the
	// address that was kept from the address phase.
	always_comb
	begin
		selCtl = 1'b0;
		selPtr = 1'b0;
		selEn = 1'b0;
		selClr = 1'b0;
		if (st_r.dataPh && st_r.dataWr)
		begin
			if (st_r.dataAddr == DCEF_EVT_CTL_OFS)
			begin
				selCtl = 1'b1;
			end
			else if (st_r.dataAddr == DCEF_RD_PTR_OFS)
			begin
				selPtr = 1'b1;
			end
			else if (st_r.dataAddr == DCEF_IRQ_EN_OFS)
			begin
				selEn = 1'b1;
			end
			else if (st_r.dataAddr == DCEF_IRQ_CLR_OFS)
			begin
				selClr = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////

	// Reads are answered from the registers as they stand at the address
	// phase, so a read pipelined straight behind a write to the same
	// register still returns the old value.
	always_comb
	begin
		// Unmapped addresses and the clear register read as zero.
		rdWord = 32'h0000_0000;
		if (haddr == DCEF_EVT_CTL_OFS)
		begin
			rdWord = ctlWord;
		end
		else if (haddr == DCEF_RD_PTR_OFS)
		begin
			rdWord = st_r.rdPtr;
		end
		else if (haddr == DCEF_IRQ_STAT_OFS)
		begin
			rdWord = {24'h00_0000, st_r.evtStat};
		end
		else if (haddr == DCEF_IRQ_EN_OFS)
		begin
			rdWord = {24'h00_0000, st_r.evtEn};
		end
	end

	////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		logic takeReq;
		takeReq = 1'b0;
		st_nxt = st_r;
		if (selCtl)
		begin
			st_nxt.wrDropEn = hwdata[DCEF_WR_DROP_EN_BIT];
			st_nxt.rdDropEn = hwdata[DCEF_RD_DROP_EN_BIT];
			st_nxt.blockEn = hwdata[DCEF_BLOCK_EN_BIT];
			st_nxt.finalEn = hwdata[DCEF_FINAL_EN_BIT];
			st_nxt.frameEn = hwdata[DCEF_FRAME_EN_BIT];
			st_nxt.splitEn = hwdata[DCEF_SPLIT_EN_BIT];
			// Condition flags take the written value; a 1 written can set
			// them, which lets software test the interrupt path.
			st_nxt.wrDropFlag = hwdata[DCEF_WR_DROP_FLAG_BIT];
			st_nxt.rdDropFlag = hwdata[DCEF_RD_DROP_FLAG_BIT];
			st_nxt.blockFlag = hwdata[DCEF_BLOCK_FLAG_BIT];
			st_nxt.finalFlag = hwdata[DCEF_FINAL_FLAG_BIT];
			st_nxt.frameFlag = hwdata[DCEF_FRAME_FLAG_BIT];
			st_nxt.splitFlag = hwdata[DCEF_SPLIT_FLAG_BIT];
			if (hwdata[DCEF_WR_SYNC_CLR_BIT])
			begin
				st_nxt.wrSeen = 1'b0;
			end
			if (hwdata[DCEF_RD_SYNC_CLR_BIT])
			begin
				st_nxt.rdSeen = 1'b0;
			end
		end
		if (selPtr)
		begin
			st_nxt.rdPtr = hwdata;
		end
		if (selEn)
		begin
			st_nxt.evtEn = hwdata[7:0];
		end
		// Hardware sets come last so they win over a clear in the same cycle.
		if (wrSyncEvt)
		begin
			st_nxt.wrSeen = 1'b1;
		end
		if (rdSyncEvt)
		begin
			st_nxt.rdSeen = 1'b1;
		end
		if (wrSyncLost)
		begin
			st_nxt.wrDropFlag = 1'b1;
		end
		if (rdSyncLost)
		begin
			st_nxt.rdDropFlag = 1'b1;
		end
		if (blockDone)
		begin
			st_nxt.blockFlag = 1'b1;
		end
		if (finalFrameDone)
		begin
			st_nxt.finalFlag = 1'b1;
		end
		if (frameDone)
		begin
			st_nxt.frameFlag = 1'b1;
		end
		if (splitOverrun)
		begin
			st_nxt.splitFlag = 1'b1;
		end
		st_nxt.evtStat = evtStatNxt;
		// Address phase; the slave is always ready, so no wait states.
		takeReq = hsel && hready && (htrans == DCEF_HTRANS_NONSEQ ||
			htrans == DCEF_HTRANS_SEQ);
		if (hready)
		begin
			st_nxt.dataPh = takeReq;
			st_nxt.dataWr = takeReq && hwrite;
			st_nxt.dataAddr = haddr;
		end
		if (takeReq && !hwrite)
		begin
			st_nxt.rdata = rdWord;
		end
		if (srst)
		begin
			st_nxt = '0;
			{st_nxt.blockEn, st_nxt.finalEn, st_nxt.frameEn, st_nxt.splitEn,
				st_nxt.wrDropEn} = DCEF_CTL_EN_RST;
			st_nxt.rdPtr = DCEF_RD_PTR_RST;
			st_nxt.evtStat = DCEF_EVT_RST;
			st_nxt.evtEn = DCEF_EVT_RST;
		end
	end

	always_ff @(posedge mclk)
	begin
		st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////

	assign hrdata = st_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign readPointer = st_r.rdPtr;
	// The sync seen bits are status only and do not request an interrupt.
	assign chanIrq = |pairIrq;
	assign evtIrq = |evtHit;

endmodule

`default_nettype wire

// File: testbench/dcef_channel_events_assertions.sv
// Port-level checks for the channel event block.
`timescale 1ns/1ps
`default_nettype none
module dcef_channel_events_assertions
(
	// Clock, reset and bus.
	input wire logic mclk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Events and outputs.
	input wire logic wrSyncLost,
	input wire logic rdSyncLost,
	input wire logic blockDone,
	input wire logic finalFrameDone,
	input wire logic frameDone,
	input wire logic splitOverrun,
	input wire logic [31:0] readPointer,
	input wire logic chanIrq,
	input wire logic evtIrq
);
	import dcef_pkg::*;
	logic wrA;
	logic anyEvt;
	logic wrD;
	logic ctlD;
	logic blkEn;
	assign wrA = hsel && hready && htrans[1] && hwrite;
	assign anyEvt = wrSyncLost || rdSyncLost || blockDone || finalFrameDone
		|| frameDone || splitOverrun;
	////////////////////////////////////////
	// Mirror of the block enable, so its default-on state can be judged.
	always_ff @(posedge mclk)
	begin
		wrD <= !srst && wrA;
		ctlD <= !srst && wrA && haddr == DCEF_EVT_CTL_OFS;
		if (srst)
			blkEn <= 1'b1;
		else if (ctlD)
			blkEn <= hwdata[DCEF_BLOCK_EN_BIT];
	end
	default clocking cb @(posedge mclk);
	endclocking
	a_bus_okay: assert property (disable iff (srst)
		hreadyout && !hresp) else $error("bus not ready or not okay");
	a_reset_clean: assert property (srst |=> !chanIrq && !evtIrq
		&& readPointer == 32'h0 && hrdata == 32'h0) else $error("bad reset");
	a_ptr_write: assert property (disable iff (srst)
		wrA && haddr == DCEF_RD_PTR_OFS |-> ##2 readPointer == $past(hwdata))
		else $error("pointer write lost");
	a_ptr_hold: assert property (disable iff (srst)
		$changed(readPointer) |-> $past(wrD) || $past(srst))
		else $error("pointer changed unasked");
	a_irq_cause: assert property (disable iff (srst)
		$rose(chanIrq) |-> $past(anyEvt) || $past(ctlD))
		else $error("irq rose without cause");
	a_irq_sticky: assert property (disable iff (srst)
		$fell(chanIrq) |-> $past(ctlD) || $past(srst))
		else $error("irq fell without write");
	a_block_default: assert property (disable iff (srst)
		blockDone && blkEn && !ctlD |=> chanIrq)
		else $error("block done gave no irq");
	a_evt_sticky: assert property (disable iff (srst)
		$fell(evtIrq) |-> $past(wrD) || $past(srst))
		else $error("event irq fell without write");
endmodule
bind dcef_channel_events dcef_channel_events_assertions i_chk (.mclk, .srst,
	.hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout,
	.hresp, .wrSyncLost, .rdSyncLost, .blockDone, .finalFrameDone,
	.frameDone, .splitOverrun, .readPointer, .chanIrq, .evtIrq);
`default_nettype wire

// File: testbench/dcef_channel_events_bench.sv
// Self-checking bench for the channel event block.
`timescale 1ns/1ps
`default_nettype none
module dcef_channel_events_bench;
	import dcef_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] ev = 8'h00;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] readPointer;
	logic chanIrq;
	logic evtIrq;
	logic [31:0] q;
	int nFail = 0;
	int checked = 0;
	always #5 mclk = ~mclk;
	dcef_channel_events i_dcef_channel_events (.mclk, .srst, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .wrSyncEvt(ev[7]), .rdSyncEvt(ev[6]),
		.wrSyncLost(ev[5]), .rdSyncLost(ev[4]), .blockDone(ev[3]),
		.finalFrameDone(ev[2]), .frameDone(ev[1]), .splitOverrun(ev[0]),
		.readPointer, .chanIrq, .evtIrq);
	////////////////////////////////////////
	task automatic tally_and_finish;
		if (nFail == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			nFail++;
		end
	endtask
	// Waits for ready at an edge; a stuck bus ends the run.
	task automatic tick;
		int n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			nFail++;
			tally_and_finish();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		hsel <= 1'b1;
		htrans <= DCEF_HTRANS_NONSEQ;
		tick();
		htrans <= 2'h0;
		hwdata <= d;
		tick();
		q = hrdata;
	endtask
	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp(nm, e, q);
	endtask
	// Looks at the levels mid-cycle, then hands back on a rising edge.
	task automatic irq(input logic c, input logic e);
		@(negedge mclk);
		cmp("chanIrq", {31'h0, c}, {31'h0, chanIrq});
		cmp("evtIrq", {31'h0, e}, {31'h0, evtIrq});
		@(posedge mclk);
	endtask
	task automatic pulse(input logic [7:0] m);
		ev <= m;
		@(posedge mclk);
		ev <= 8'h00;
	endtask
	////////////////////////////////////////
	task automatic t_reset;
		rd("ctl", DCEF_EVT_CTL_OFS, 32'h80);
		rd("ptr", DCEF_RD_PTR_OFS, 32'h0);
		rd("hole", 8'h14, 32'h0);
		pulse(8'h08);
		irq(1'b1, 1'b0);
		rd("ctl", DCEF_EVT_CTL_OFS, 32'hc0);
	endtask
	task automatic t_ptr;
		bus(1'b1, DCEF_RD_PTR_OFS, 32'ha5c3_5a3c);
		rd("ptr", DCEF_RD_PTR_OFS, 32'ha5c3_5a3c);
		cmp("readPointer", 32'ha5c3_5a3c, readPointer);
	endtask
	// Flag k sits at bit 2k with its enable just above it.
	task automatic t_flags;
		logic [31:0] f;
		for (int k = 0; k < 6; k++)
		begin
			f = 32'h1 << (2 * k);
			bus(1'b1, DCEF_EVT_CTL_OFS, 32'h0);
			pulse(8'h01 << k);
			irq(1'b0, 1'b0);
			rd("flag", DCEF_EVT_CTL_OFS, f);
			bus(1'b1, DCEF_EVT_CTL_OFS, f * 3);
			irq(1'b1, 1'b0);
			bus(1'b1, DCEF_EVT_CTL_OFS, f * 2);
			irq(1'b0, 1'b0);
		end
	endtask
	task automatic t_sync;
		pulse(8'hc0);
		irq(1'b0, 1'b0);
		rd("sync", DCEF_EVT_CTL_OFS, 32'h5800);
		bus(1'b1, DCEF_EVT_CTL_OFS, 32'h2000);
		rd("sync", DCEF_EVT_CTL_OFS, 32'h4000);
		bus(1'b1, DCEF_EVT_CTL_OFS, 32'h0);
		rd("sync", DCEF_EVT_CTL_OFS, 32'h4000);
		bus(1'b1, DCEF_EVT_CTL_OFS, 32'h8000);
		rd("sync", DCEF_EVT_CTL_OFS, 32'h0);
	endtask
	// The event lands on the edge that ends the clearing write.
	task automatic t_race;
		fork
			bus(1'b1, DCEF_EVT_CTL_OFS, 32'h8);
			begin
				@(posedge mclk);
				pulse(8'h02);
			end
		join
		rd("race", DCEF_EVT_CTL_OFS, 32'hc);
		irq(1'b1, 1'b0);
	endtask
	task automatic t_evt;
		bus(1'b1, DCEF_IRQ_EN_OFS, 32'h7e);
		rd("en", DCEF_IRQ_EN_OFS, 32'h7e);
		rd("stat", DCEF_IRQ_STAT_OFS, 32'hff);
		bus(1'b1, DCEF_IRQ_CLR_OFS, 32'hfe);
		rd("stat", DCEF_IRQ_STAT_OFS, 32'h1);
		irq(1'b1, 1'b0);
		pulse(8'h10);
		irq(1'b1, 1'b1);
		bus(1'b1, DCEF_IRQ_CLR_OFS, 32'h7f);
		rd("stat", DCEF_IRQ_STAT_OFS, 32'h0);
		rd("clr", DCEF_IRQ_CLR_OFS, 32'h0);
		irq(1'b1, 1'b0);
	endtask
	initial
	begin
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_ptr();
		t_flags();
		t_sync();
		t_race();
		t_evt();
		tally_and_finish();
	end
endmodule
`default_nettype wire
